// file: logic/lfrx_irq_defs.vh
// Purpose: Constants for the receiver interrupt and status block.
// Assumes: One 125 MHz clock; 32-bit classic Wishbone register port.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
`ifndef LFRX_IRQ_DEFS_VH
`define LFRX_IRQ_DEFS_VH

// ---------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------
`define ADDR_W              4
`define OFS_IRQ_CONTROL     4'h0
`define OFS_STATUS_FLAGS    4'h4
`define OFS_RX_BYTE         4'h8
`define OFS_RAW_DETECTOR    4'hC

// ---------------------------------------------------------------------
// Control register fields and reset value
// ---------------------------------------------------------------------
`define CTL_DR_IE           7
`define CTL_ER_IE           6
`define CTL_CD_IE           5
`define CTL_ID_IE           4
`define CTL_DECODE_EN       3
`define CTL_VALID_EN        2
`define CTL_TMO_HI          1
`define CTL_TMO_LO          0
`define CTL_RESET           8'h0C

// ---------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------
`define ST_DR               7
`define ST_ER               6
`define ST_CD               5
`define ST_ID               4
`define ST_OVF              3
`define ST_EOM              2
`define ST_SNIFF            1
`define ST_ACK              0

// ---------------------------------------------------------------------
// Event toggle lanes coming from the receiver clock domain
// ---------------------------------------------------------------------
`define EV_W                7
`define EV_BYTE             0
`define EV_ERR              1
`define EV_CVALID           2
`define EV_CLOST            3
`define EV_ID               4
`define EV_EOM              5
`define EV_SYNC             6

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define CLK_PERIOD_NS       8
`define MS_NS               1000000
`define TMO_OFF             2'h0
`define TMO_SHORT           2'h1
`define TMO_MID             2'h2
`define TMO_LONG            2'h3
`define TMO_SHORT_MS        8'h08
`define TMO_MID_MS          8'h18
`define TMO_LONG_MS         8'h30

`endif

// file: logic/cdc_sync_bus.v
// Purpose: Two-flop synchroniser for a group of asynchronous lines.
// Assumes: Each line is a level or a toggle owned by another domain.
// Notes:   Change pulses are taken only from the second flop onward.
`timescale 1ns/10ps

module cdc_sync_bus #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o,
	output wire [W-1:0] chg_o
);

	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;
	reg [W-1:0] prev_ff;

	// These flops keep shifting while reset is held, so a toggle line
	// that rests high is not taken for a fresh event after release.
	// Reset must therefore be held for at least three clocks.
	always @(posedge clk_i) begin
		meta_ff <= d_i;
		sync_ff <= meta_ff;
		prev_ff <= sync_ff;
	end

	assign q_o   = sync_ff;
	// Change pulses are masked while reset is held.
	assign chg_o = (sync_ff ^ prev_ff) & {W{~rst_i}};

endmodule

// file: logic/lfrx_irq_status.v
// Purpose: Interrupt enables, status flags and decode controls of the
//          low-frequency wake-up receiver, on a classic Wishbone port.
// Assumes: Receiver events arrive as toggles from the receiver clock.
// Notes:   Mode, page and carrier count inputs are same-clock signals.
//
// Summary of operation
// - Data-ready enable gates byte-ready flag to irq.
// - Error enable gates receive-error flag to irq.
// - Carrier enable ignored in data mode unless undecoded.
// - ID enable gates ID-match flag to irq.
// - No global mask; only local enables gate.
// - Reset clears four enables; all are read/write.
// - Decode off: no data, error, ID flags.
// - Decode off: poll raw bit; reset sets decode.
// - Validation enable switches carrier validation; reset one.
// - Timeout select: none, 8, 24, 48 ms.
// - Byte flag: ack write, byte read, reset clear.
// - Error flag on bad bit, data mode only.
// - Error flag read-only; ack write or reset clear.
// - Carrier flag after count validations, not toggle mode.
// - Carrier flag read-only; ack write or reset clear.
// - Status reachable only with page select zero.
// - Ack write clears six flags; reads zero.
// - ID flag in data mode, even without data.
// - Mode select zero means data receive mode.
`timescale 1ns/10ps

`include "lfrx_irq_defs.vh"

module lfrx_irq_status #(
	parameter CC_W      = 4,
	parameter MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
	input  wire              clk_i,
	input  wire              rst_i,
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [`ADDR_W-1:0] wb_adr_i,
	input  wire [31:0]       wb_dat_i,
	output wire [31:0]       wb_dat_o,
	output wire              wb_ack_o,
	input  wire [`EV_W-1:0]  rx_event_tgl_i,
	input  wire [7:0]        rx_byte_i,
	input  wire              raw_detector_output_i,
	input  wire              sync_search_active_i,
	input  wire              carrier_mode_select_i,
	input  wire              toggle_mode_i,
	input  wire              register_page_select_i,
	input  wire [CC_W-1:0]   carrier_count_setting_i,
	output wire              irq_o,
	output wire              digital_decode_enable_o,
	output wire              carrier_validation_enable_o,
	output wire [1:0]        sync_search_timeout_sel_o,
	output wire              low_power_sniff_o,
	output wire              receiver_off_o
);

	// -----------------------------------------------------------------
	// Synchronisers for everything owned by the receiver clock
	// -----------------------------------------------------------------
	wire [`EV_W-1:0] ev_pulse;
	wire [7:0]       byte_sync;
	wire [1:0]       lvl_sync;

	cdc_sync_bus #(.W(`EV_W)) u_sync_ev (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (rx_event_tgl_i),
		.q_o   (),
		.chg_o (ev_pulse)
	);

	// The byte is stable well before its toggle arrives, so its
	// synchronised copy has settled when the event pulse is seen.
	cdc_sync_bus #(.W(8)) u_sync_byte (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (rx_byte_i),
		.q_o   (byte_sync),
		.chg_o ()
	);

	cdc_sync_bus #(.W(2)) u_sync_lvl (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({sync_search_active_i, raw_detector_output_i}),
		.q_o   (lvl_sync),
		.chg_o ()
	);

	wire raw_level     = lvl_sync[0];
	wire search_active = lvl_sync[1];

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	reg [7:0]      ctl_ff;
	reg            dr_ff;
	reg            er_ff;
	reg            cd_ff;
	reg            id_ff;
	reg            ovf_ff;
	reg            eom_ff;
	reg            sniff_ff;
	reg [7:0]      rx_byte_ff;
	reg [CC_W-1:0] cvalid_cnt_ff;
	reg            ack_ff;
	reg [31:0]     rdat_ff;
	reg            irq_ff;
	reg [16:0]     ms_div_ff;
	reg            ms_tick_ff;
	reg [7:0]      tmo_left_ff;
	reg            tmo_run_ff;
	reg            search_prev_ff;
	reg            rx_off_ff;

	// Bus access is acted on once, in the cycle before ack rises.
	// The ack is registered, so every access is answered one cycle
	// after it is taken; masking with ack_ff keeps a strobe that is
	// held on from acting twice. Refused accesses are still answered.
	wire bus_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
	wire bus_rd    = bus_req & ~wb_we_i;
	wire page_zero = ~register_page_select_i;

	wire data_mode  = (carrier_mode_select_i == 1'b0);
	wire decode_on  = ctl_ff[`CTL_DECODE_EN];
	wire decode_ok  = decode_on & data_mode;

	wire ctl_wr = bus_wr & (wb_adr_i == `OFS_IRQ_CONTROL);
	wire st_wr  = bus_wr & page_zero & (wb_adr_i == `OFS_STATUS_FLAGS);
	wire ack_wr = st_wr & wb_dat_i[`ST_ACK];
	wire byte_rd = bus_rd & page_zero & (wb_adr_i == `OFS_RX_BYTE);

	// -----------------------------------------------------------------
	// Flag set terms
	// -----------------------------------------------------------------
	wire set_dr  = ev_pulse[`EV_BYTE] & decode_ok;
	wire set_er  = ev_pulse[`EV_ERR] & decode_ok;
	wire set_id  = ev_pulse[`EV_ID] & decode_ok;
	wire set_ovf = set_dr & dr_ff;
	wire set_eom = ev_pulse[`EV_EOM] & decode_ok;

	// Outside toggle mode, carrier counting runs in carrier mode, or when undecoded data
	// mode hands carrier detection back to software.
	wire cd_mode = (~data_mode | ~decode_on) & ~toggle_mode_i;
	wire cvalid  = ev_pulse[`EV_CVALID] & ctl_ff[`CTL_VALID_EN];
	// A count setting of zero is reached only when the counter wraps,
	// so software should program a count of one or more.
	wire [CC_W-1:0] cvalid_nxt = cvalid_cnt_ff + {{(CC_W-1){1'b0}}, 1'b1};
	wire set_cd  = cd_mode & cvalid & (cvalid_nxt == carrier_count_setting_i);

	// -----------------------------------------------------------------
	// Control register
	// -----------------------------------------------------------------
	// Decode and validation come out of reset enabled, so the receiver
	// works before software has touched this register.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctl_ff <= `CTL_RESET;
		end else if (ctl_wr) begin
			ctl_ff <= wb_dat_i[7:0];
		end
	end

	// -----------------------------------------------------------------
	// Status flags; a set in the clearing cycle wins
	// -----------------------------------------------------------------
	// One acknowledge write clears all six flags; a zero in that bit
	// leaves them alone. The sniff bit is plain read/write storage.
	always @(posedge clk_i) begin
		if (rst_i) begin
			dr_ff    <= 1'b0;
			er_ff    <= 1'b0;
			cd_ff    <= 1'b0;
			id_ff    <= 1'b0;
			ovf_ff   <= 1'b0;
			eom_ff   <= 1'b0;
			sniff_ff <= 1'b1;
		end else begin
			dr_ff  <= set_dr | (dr_ff & ~ack_wr & ~byte_rd);
			er_ff  <= set_er | (er_ff & ~ack_wr);
			cd_ff  <= set_cd | (cd_ff & ~ack_wr);
			id_ff  <= set_id | (id_ff & ~ack_wr);
			ovf_ff <= set_ovf | (ovf_ff & ~ack_wr);
			eom_ff <= set_eom | (eom_ff & ~ack_wr);
			if (st_wr) begin
				sniff_ff <= wb_dat_i[`ST_SNIFF];
			end
		end
	end

	// -----------------------------------------------------------------
	// Received byte and carrier validation count
	// -----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_byte_ff    <= 8'h00;
			cvalid_cnt_ff <= {CC_W{1'b0}};
		end else begin
			if (set_dr) begin
				rx_byte_ff <= byte_sync;
			end
			// A lost carrier breaks the run of consecutive validations.
			if (ev_pulse[`EV_CLOST] | ~cd_mode | set_cd) begin
				cvalid_cnt_ff <= {CC_W{1'b0}};
			end else if (cvalid) begin
				cvalid_cnt_ff <= cvalid_nxt;
			end
		end
	end

	// -----------------------------------------------------------------
	// SYNC search timeout, counted in milliseconds
	// -----------------------------------------------------------------
	function [7:0] tmo_ms;
		input [1:0] sel;
		begin
			case (sel)
			`TMO_SHORT: tmo_ms = `TMO_SHORT_MS;
			`TMO_MID:   tmo_ms = `TMO_MID_MS;
			`TMO_LONG:  tmo_ms = `TMO_LONG_MS;
			default:    tmo_ms = 8'h00;
			endcase
		end
	endfunction

	wire [1:0] tmo_sel     = ctl_ff[`CTL_TMO_HI:`CTL_TMO_LO];
	wire       search_rise = search_active & ~search_prev_ff;

	// The millisecond tick stands in for the receiver oscillator, so
	// the search period is nominal to within one tick.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ms_div_ff  <= 17'h00000;
			ms_tick_ff <= 1'b0;
		end else if (ms_div_ff == MS_CYCLES[16:0] - 17'h00001) begin
			ms_div_ff  <= 17'h00000;
			ms_tick_ff <= 1'b1;
		end else begin
			ms_div_ff  <= ms_div_ff + 17'h00001;
			ms_tick_ff <= 1'b0;
		end
	end

	// Leaving the search clears the off request, so the next search
	// starts with the receiver switched on.
	always @(posedge clk_i) begin
		if (rst_i) begin
			search_prev_ff <= 1'b0;
			tmo_left_ff    <= 8'h00;
			tmo_run_ff     <= 1'b0;
			rx_off_ff      <= 1'b0;
		end else begin
			search_prev_ff <= search_active;
			if (search_rise) begin
				tmo_left_ff <= tmo_ms(tmo_sel);
				tmo_run_ff  <= data_mode & (tmo_sel != `TMO_OFF);
				rx_off_ff   <= 1'b0;
			end else if (ev_pulse[`EV_SYNC] | ~search_active) begin
				tmo_run_ff <= 1'b0;
				if (~search_active) begin
					rx_off_ff <= 1'b0;
				end
			end else if (tmo_run_ff & ms_tick_ff) begin
				if (tmo_left_ff == 8'h01) begin
					tmo_run_ff <= 1'b0;
					rx_off_ff  <= 1'b1;
				end
				tmo_left_ff <= tmo_left_ff - 8'h01;
			end
		end
	end

	// -----------------------------------------------------------------
	// Interrupt request
	// -----------------------------------------------------------------
	// There is no global mask: only the local enables gate the request,
	// which stays high until every enabled flag has been cleared.
	wire cd_ie_eff = ctl_ff[`CTL_CD_IE] & (~data_mode | ~decode_on);
	wire irq_nxt = (dr_ff & ctl_ff[`CTL_DR_IE])
	             | (er_ff & ctl_ff[`CTL_ER_IE])
	             | (cd_ff & cd_ie_eff)
	             | (id_ff & ctl_ff[`CTL_ID_IE]);

	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= irq_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Wishbone read data and acknowledge
	// -----------------------------------------------------------------
	// A read of the byte register also clears the byte-ready flag, which
	// is why the read strobe is taken only once per access.
	wire [7:0] status_rd = {dr_ff, er_ff, cd_ff, id_ff,
	                        ovf_ff, eom_ff, sniff_ff, 1'b0};
	reg  [7:0] rd_mux;

	always @* begin
		rd_mux = 8'h00;
		case (wb_adr_i)
		`OFS_IRQ_CONTROL:  rd_mux = ctl_ff;
		`OFS_STATUS_FLAGS: rd_mux = page_zero ? status_rd : 8'h00;
		`OFS_RX_BYTE:      rd_mux = page_zero ? rx_byte_ff : 8'h00;
		`OFS_RAW_DETECTOR: rd_mux = {7'h00, raw_level};
		default:           rd_mux = 8'h00;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h00000000;
		end else begin
			ack_ff <= bus_req;
			if (bus_rd) begin
				rdat_ff <= {24'h000000, rd_mux};
			end
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign wb_dat_o                    = rdat_ff;
	assign wb_ack_o                    = ack_ff;
	assign irq_o                       = irq_ff;
	assign digital_decode_enable_o     = ctl_ff[`CTL_DECODE_EN];
	assign carrier_validation_enable_o = ctl_ff[`CTL_VALID_EN];
	assign sync_search_timeout_sel_o   = ctl_ff[`CTL_TMO_HI:`CTL_TMO_LO];
	assign low_power_sniff_o           = sniff_ff;
	assign receiver_off_o              = rx_off_ff;

endmodule

// file: test/lfrx_irq_status_properties.sv
// Purpose: Port-level properties of the receiver interrupt block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached by bind to every instance of the block.
`timescale 1ns/10ps
`include "lfrx_irq_defs.vh"

module lfrx_irq_status_properties #(
	parameter CC_W      = 4,
	parameter MS_CYCLES = 10
) (
	input wire               clk_i,
	input wire               rst_i,
	input wire               wb_cyc_i,
	input wire               wb_stb_i,
	input wire               wb_we_i,
	input wire [3:0]         wb_sel_i,
	input wire [`ADDR_W-1:0] wb_adr_i,
	input wire [31:0]        wb_dat_i,
	input wire [31:0]        wb_dat_o,
	input wire               wb_ack_o,
	input wire [`EV_W-1:0]   rx_event_tgl_i,
	input wire [7:0]         rx_byte_i,
	input wire               raw_detector_output_i,
	input wire               sync_search_active_i,
	input wire               carrier_mode_select_i,
	input wire               toggle_mode_i,
	input wire               register_page_select_i,
	input wire [CC_W-1:0]    carrier_count_setting_i,
	input wire               irq_o,
	input wire               digital_decode_enable_o,
	input wire               carrier_validation_enable_o,
	input wire [1:0]         sync_search_timeout_sel_o,
	input wire               low_power_sniff_o,
	input wire               receiver_off_o
);
	wire take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire st_sel = take & (wb_adr_i == `OFS_STATUS_FLAGS)
		& ~register_page_select_i;
	wire hid    = take & ~wb_we_i & register_page_select_i
		& (wb_adr_i == `OFS_STATUS_FLAGS | wb_adr_i == `OFS_RX_BYTE);
	wire ctl_wr = take & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == `OFS_IRQ_CONTROL);
	wire ack_wr = st_sel & wb_we_i & wb_sel_i[0] & wb_dat_i[0];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_follows: assert property (take |=> wb_ack_o)
		else $error("no ack after a request");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_upper_zero: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read data not zero");
	chk_page_hides: assert property (hid |=> wb_dat_o == 32'h0)
		else $error("hidden register visible");
	chk_ack_reads0: assert property (
		st_sel & ~wb_we_i |=> !wb_dat_o[0])
		else $error("acknowledge bit read as one");
	// Quiet event lanes are required, since a late event may set a flag.
	chk_ack_clears: assert property (
		ack_wr && rx_event_tgl_i == $past(rx_event_tgl_i, 6)
		|=> ##1 !irq_o)
		else $error("irq still high after acknowledge");
	chk_reset_vals: assert property (
		$fell(rst_i) |-> !irq_o && !wb_ack_o && digital_decode_enable_o
		&& carrier_validation_enable_o && !receiver_off_o
		&& sync_search_timeout_sel_o == 2'h0)
		else $error("wrong value after reset");
	chk_ctl_by_write: assert property (
		$changed({digital_decode_enable_o, carrier_validation_enable_o,
		sync_search_timeout_sel_o}) |-> $past(ctl_wr))
		else $error("control output changed without a write");
endmodule

bind lfrx_irq_status lfrx_irq_status_properties #(
	.CC_W(CC_W), .MS_CYCLES(MS_CYCLES)
) props (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
	.wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_event_tgl_i,
	.rx_byte_i, .raw_detector_output_i, .sync_search_active_i,
	.carrier_mode_select_i, .toggle_mode_i, .register_page_select_i,
	.carrier_count_setting_i, .irq_o, .digital_decode_enable_o,
	.carrier_validation_enable_o, .sync_search_timeout_sel_o,
	.low_power_sniff_o, .receiver_off_o
);

// file: test/lfrx_event_source.sv
// Purpose: Model of the detector and decoder that feed the block.
// Assumes: Events are signalled by toggling one lane per event.
// Notes:   Driven from the bench through send and direct assignment.
`timescale 1ns/10ps
`include "lfrx_irq_defs.vh"

module lfrx_event_source (
	input  wire             clk_i,
	output reg [`EV_W-1:0]  rx_event_tgl_o,
	output reg [7:0]        rx_byte_o,
	output reg              raw_detector_output_o,
	output reg              sync_search_active_o
);
	initial begin
		rx_event_tgl_o = {`EV_W{1'h0}};
		rx_byte_o = 8'h00;
		raw_detector_output_o = 1'h0;
		sync_search_active_o = 1'h0;
	end

	// The byte leads its toggle and is held long after it, because the
	// block captures it only once the toggle is synchronised.
	task send(input integer lane, input [7:0] b);
		begin
			@(posedge clk_i);
			rx_byte_o <= b;
			@(posedge clk_i);
			rx_event_tgl_o[lane] <= ~rx_event_tgl_o[lane];
			repeat (6) @(posedge clk_i);
		end
	endtask
endmodule

// file: test/lfrx_irq_status_bench.sv
// Purpose: Self-checking bench of the receiver interrupt block.
// Assumes: 125 MHz clock; one millisecond shortened to 10 cycles.
// Notes:   Each scenario judges its own results.
`timescale 1ns/10ps
`include "lfrx_irq_defs.vh"

module lfrx_irq_status_bench;
	reg         clk_i = 1'h0;
	reg         rst_i = 1'h1;
	reg         wb_cyc_i = 1'h0;
	reg         wb_stb_i = 1'h0;
	reg         wb_we_i = 1'h0;
	reg  [3:0]  wb_sel_i = 4'hF;
	reg  [3:0]  wb_adr_i = 4'h0;
	reg  [31:0] wb_dat_i = 32'h0;
	reg         carrier_mode_select_i = 1'h0;
	reg         toggle_mode_i = 1'h0;
	reg         register_page_select_i = 1'h0;
	reg  [3:0]  carrier_count_setting_i = 4'h2;
	wire [31:0] wb_dat_o;
	wire [6:0]  rx_event_tgl_i;
	wire [7:0]  rx_byte_i;
	wire [1:0]  sync_search_timeout_sel_o;
	wire        wb_ack_o, irq_o, raw_detector_output_i, receiver_off_o;
	wire        sync_search_active_i, low_power_sniff_o;
	wire        digital_decode_enable_o, carrier_validation_enable_o;
	integer     errors, n_checks;

	lfrx_irq_status #(.CC_W(4), .MS_CYCLES(10)) DUT (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
		.wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_event_tgl_i,
		.rx_byte_i, .raw_detector_output_i, .sync_search_active_i,
		.carrier_mode_select_i, .toggle_mode_i, .register_page_select_i,
		.carrier_count_setting_i, .irq_o, .digital_decode_enable_o,
		.carrier_validation_enable_o, .sync_search_timeout_sel_o,
		.low_power_sniff_o, .receiver_off_o);
	lfrx_event_source src (.clk_i, .rx_event_tgl_o(rx_event_tgl_i),
		.rx_byte_o(rx_byte_i), .raw_detector_output_o(raw_detector_output_i),
		.sync_search_active_o(sync_search_active_i));

	always #4 clk_i = ~clk_i;

	// ------------------------------------------------------------------
	// Bus and checking helpers
	// ------------------------------------------------------------------
	task test_done;
		begin
			if (errors == 0 && n_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task wb(input [3:0] a, input w, input [7:0] d, output [31:0] q);
		integer i;
		begin
			@(posedge clk_i);
			wb_cyc_i <= 1'h1;
			wb_stb_i <= 1'h1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_dat_i <= {24'h0, d};
			for (i = 0; i < 20 && wb_ack_o !== 1'h1; i = i + 1)
				@(posedge clk_i);
			q = wb_dat_o;
			wb_cyc_i <= 1'h0;
			wb_stb_i <= 1'h0;
			if (i == 20) begin
				errors = errors + 1;
				$display("CHECK FAILED %0t no bus answer", $time);
				test_done;
			end
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		reg [31:0] q;
		begin
			wb(a, 1'h0, 8'h00, q);
			chk(q, {24'h0, e});
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		reg [31:0] q;
		wb(a, 1'h1, d, q);
	endtask
	task irq_is(input e);
		begin
			@(posedge clk_i);
			chk({31'h0, irq_o}, {31'h0, e});
		end
	endtask
	task clr_flags;
		wr(`OFS_STATUS_FLAGS, 8'h03);
	endtask
	task carrier(input integer n);
		integer k;
		begin
			src.send(`EV_CLOST, 8'h00);
			for (k = 0; k < n; k = k + 1)
				src.send(`EV_CVALID, 8'h00);
		end
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_ctl;
		integer k;
		begin
			rd(`OFS_IRQ_CONTROL, 8'h0C);
			rd(`OFS_STATUS_FLAGS, 8'h02);
			chk(low_power_sniff_o, 1);
			wr(`OFS_STATUS_FLAGS, 8'h00);
			chk(low_power_sniff_o, 0);
			wr(`OFS_STATUS_FLAGS, 8'h02);
			chk(low_power_sniff_o, 1);
			wr(`OFS_IRQ_CONTROL, 8'hF3);
			rd(`OFS_IRQ_CONTROL, 8'hF3);
			chk({digital_decode_enable_o, carrier_validation_enable_o}, 0);
			for (k = 0; k < 4; k = k + 1) begin
				wr(`OFS_IRQ_CONTROL, 8'h0C | k[7:0]);
				chk(sync_search_timeout_sel_o, k[1:0]);
			end
		end
	endtask
	task t_byte;
		begin
			clr_flags;
			wr(`OFS_IRQ_CONTROL, 8'h8C);
			src.send(`EV_BYTE, 8'hA5);
			irq_is(1'h1);
			rd(`OFS_STATUS_FLAGS, 8'h82);
			rd(`OFS_RX_BYTE, 8'hA5);
			rd(`OFS_STATUS_FLAGS, 8'h02);
			irq_is(1'h0);
			src.send(`EV_BYTE, 8'h11);
			src.send(`EV_BYTE, 8'h5A);
			src.send(`EV_EOM, 8'h00);
			rd(`OFS_STATUS_FLAGS, 8'h8E);
			rd(`OFS_RX_BYTE, 8'h5A);
			clr_flags;
			rd(`OFS_STATUS_FLAGS, 8'h02);
			wr(`OFS_IRQ_CONTROL, 8'hD4);
			src.send(`EV_BYTE, 8'h3C);
			src.send(`EV_ERR, 8'h00);
			irq_is(1'h0);
			rd(`OFS_STATUS_FLAGS, 8'h02);
		end
	endtask
	task t_err;
		begin
			wr(`OFS_IRQ_CONTROL, 8'h0C);
			src.send(`EV_ERR, 8'h00);
			irq_is(1'h0);
			wr(`OFS_STATUS_FLAGS, 8'h42);
			rd(`OFS_STATUS_FLAGS, 8'h42);
			wr(`OFS_IRQ_CONTROL, 8'h4C);
			irq_is(1'h1);
			clr_flags;
			irq_is(1'h0);
			wr(`OFS_IRQ_CONTROL, 8'h1C);
			src.send(`EV_ID, 8'h00);
			irq_is(1'h1);
			rd(`OFS_STATUS_FLAGS, 8'h12);
			clr_flags;
			rd(`OFS_STATUS_FLAGS, 8'h02);
		end
	endtask
	task t_car;
		begin
			@(posedge clk_i);
			carrier_mode_select_i <= 1'h1;
			wr(`OFS_IRQ_CONTROL, 8'h2C);
			carrier(1);
			rd(`OFS_STATUS_FLAGS, 8'h02);
			src.send(`EV_CVALID, 8'h00);
			irq_is(1'h1);
			rd(`OFS_STATUS_FLAGS, 8'h22);
			clr_flags;
			toggle_mode_i <= 1'h1;
			carrier(2);
			rd(`OFS_STATUS_FLAGS, 8'h02);
			toggle_mode_i <= 1'h0;
			carrier_mode_select_i <= 1'h0;
			carrier_count_setting_i <= 4'h3;
			wr(`OFS_IRQ_CONTROL, 8'h24);
			carrier(2);
			irq_is(1'h0);
			src.send(`EV_CVALID, 8'h00);
			irq_is(1'h1);
			// The flag stays set: decoding back on must mask its enable.
			wr(`OFS_IRQ_CONTROL, 8'h2C);
			carrier(2);
			irq_is(1'h0);
			rd(`OFS_STATUS_FLAGS, 8'h22);
			clr_flags;
		end
	endtask
	task t_page;
		begin
			rd(`OFS_RAW_DETECTOR, 8'h00);
			src.raw_detector_output_o <= 1'h1;
			register_page_select_i <= 1'h1;
			rd(`OFS_STATUS_FLAGS, 8'h00);
			rd(`OFS_RX_BYTE, 8'h00);
			register_page_select_i <= 1'h0;
			rd(`OFS_RAW_DETECTOR, 8'h01);
		end
	endtask
	task t_tmo;
		begin
			wr(`OFS_IRQ_CONTROL, 8'h0D);
			src.sync_search_active_o <= 1'h1;
			repeat (60) @(posedge clk_i);
			chk(receiver_off_o, 0);
			repeat (50) @(posedge clk_i);
			chk(receiver_off_o, 1);
			src.sync_search_active_o <= 1'h0;
			repeat (4) @(posedge clk_i);
			chk(receiver_off_o, 0);
			src.sync_search_active_o <= 1'h1;
			repeat (20) @(posedge clk_i);
			src.send(`EV_SYNC, 8'h00);
			repeat (100) @(posedge clk_i);
			chk(receiver_off_o, 0);
			src.sync_search_active_o <= 1'h0;
		end
	endtask

	initial begin
		errors = 0;
		n_checks = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		t_ctl;
		t_byte;
		t_err;
		t_car;
		t_page;
		t_tmo;
		test_done;
	end
endmodule
